// ===== design/mebp_bus_pins.sv
`timescale 1ns/1ns
module mebp_bus_pins
	import mebp_pkg::*;
(
	// clock and reset
	input  wire logic          clk,
	input  wire logic          srst,
	// pins
	input  wire mebp_pin_in_t  pins_in,
	output mebp_pin_out_t      pins,
	// straps and mode
	input  wire logic [1:0]    lock_bits,
	input  wire logic          program_pulse_input_mode,
	input  wire logic          program_pulse_input_verify,
	input  wire logic [7:0]    verify_byte,
	// port latch writes and pin reads
	input  wire logic          port_wr,
	input  wire logic [1:0]    port_sel,
	input  wire logic [7:0]    port_wdata,
	output logic [31:0]        port_pins,
	// program fetch
	input  wire logic [15:0]   fetch_addr,
	output logic [7:0]         code_byte,
	output logic               code_valid,
	output logic               fetch_external,
	// external data access
	input  wire logic          xd_valid,
	input  wire mebp_xreq_t    xd_req,
	output logic               xd_ready,
	output logic [7:0]         xd_rdata,
	output logic               xd_done,
	// serial, interrupts, timers
	input  wire logic          serial_tx,
	output logic [4:0]         alt_in,
	// programming side
	output logic [7:0]         program_pulse_input_byte,
	output logic [15:0]        program_pulse_input_addr,
	output logic               program_pulse_input,
	output logic               in_reset
);

	logic [3:0]    phase;
	mebp_mc_t      mc;
	mebp_mc_t      next_mc;
	mebp_xreq_t    xq;
	logic [4:0]    rst_cnt;
	logic          strap_latch_n;
	logic [7:0]    p0_latch;
	logic [7:0]    p1_latch;
	logic [7:0]    port_two_latch;
	logic [7:0]    p3_latch;
	logic          xd_take;
	mebp_pin_out_t next_pins;

	function automatic logic in_win(input logic [3:0] p, input logic [3:0] b,
		input logic [3:0] e);
		in_win = (p >= b) && (p <= e);
	endfunction

	// quasi-bidirectional: only a zero is driven, a one rides the pull-up
	function automatic logic [7:0] weak_oe(input logic [7:0] v);
		weak_oe = ~v;
	endfunction

	// reset pin must stay high for a full count before the core resets
	always_ff @(posedge clk)
	begin
		if (srst || !pins_in.reset_pin)
			rst_cnt <= 5'h00;
		else if (rst_cnt != RST_MAX)
			rst_cnt <= rst_cnt + 5'h01;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			in_reset <= 1'b1;
		else if (rst_cnt == RST_MAX)
			in_reset <= 1'b1;
		else if (!pins_in.reset_pin)
			in_reset <= 1'b0;
	end

	// strap sampled while reset is held
	always_ff @(posedge clk)
	begin
		if (in_reset)
			strap_latch_n <= pins_in.external_fetch_select_n;
	end

	always_comb
	begin
		if (lock_bits != LOCK_NONE)
			fetch_external = !strap_latch_n;
		else
			fetch_external = !pins_in.external_fetch_select_n;
	end

	always_ff @(posedge clk)
	begin
		if (srst || in_reset || phase == PH_LAST)
			phase <= 4'h0;
		else
			phase <= phase + 4'h1;
	end

	assign xd_ready = (phase == PH_LAST) && !in_reset && !program_pulse_input_mode;
	assign xd_take  = xd_valid && xd_ready;

	always_comb
	begin
		next_mc = mc;
		if (in_reset || program_pulse_input_mode)
			next_mc = MC_IDLE;
		else if (phase == PH_LAST)
		begin
			if (xd_take)
				next_mc = MC_DATA;
			else if (fetch_external)
				next_mc = MC_FETCH;
			else
				next_mc = MC_IDLE;
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			mc <= MC_IDLE;
		else
			mc <= next_mc;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			xq <= '0;
		else if (xd_take)
			xq <= xd_req;
	end

	// port latches return to all ones on reset
	always_ff @(posedge clk)
	begin
		if (srst || in_reset)
		begin
			p0_latch       <= BYTE_ONES;
			p1_latch       <= BYTE_ONES;
			port_two_latch <= BYTE_ONES;
			p3_latch       <= BYTE_ONES;
		end
		else if (port_wr)
		begin
			case (port_sel)
				2'h0: p0_latch <= port_wdata;
				2'h1: p1_latch <= port_wdata;
				2'h2: port_two_latch <= port_wdata;
				default: p3_latch <= port_wdata;
			endcase
		end
	end

	always_comb
	begin
		logic       ale_slot;
		logic       strobe;
		logic [7:0] p3v;
		ale_slot = in_win(phase, ALE_SLOT0, ALE_END0) || in_win(phase, ALE_SLOT1, ALE_END1);
		strobe   = (mc == MC_DATA) && in_win(phase, XS_BEG, XS_END);
		p3v      = p3_latch;
		p3v[P3_TXD] = p3_latch[P3_TXD] & serial_tx;
		p3v[P3_WR]  = p3_latch[P3_WR] & !(strobe && xq.write);
		p3v[P3_RD]  = p3_latch[P3_RD] & !(strobe && !xq.write);
		next_pins.p0_o   = p0_latch;
		next_pins.p0_oe  = ~p0_latch;
		next_pins.p1_o   = p1_latch;
		next_pins.p1_oe  = weak_oe(p1_latch);
		next_pins.p2_o   = port_two_latch;
		next_pins.p2_oe  = weak_oe(port_two_latch);
		next_pins.p3_o   = p3v;
		next_pins.p3_oe  = weak_oe(p3v);
		next_pins.ale_o  = ale_slot && !in_reset;
		next_pins.ale_oe = 1'b1;
		next_pins.program_store_read_strobe_n = 1'b1;
		case (mc)
			MC_FETCH:
			begin
				next_pins.p2_o  = fetch_addr[15:8];
				next_pins.p2_oe = BYTE_ONES;
				next_pins.p0_oe = BYTE_ONES;
				next_pins.p0_o  = ale_slot ? fetch_addr[7:0] : BYTE_ONES;
				if (!ale_slot)
					next_pins.p0_oe = BYTE_ZERO;
				next_pins.program_store_read_strobe_n =
					!(in_win(phase, RDS_BEG0, RDS_END0) ||
					  in_win(phase, RDS_BEG1, RDS_END1));
			end
			MC_DATA:
			begin
				next_pins.ale_o = in_win(phase, ALE_SLOT0, ALE_END0);
				next_pins.p2_o  = xq.wide ? xq.addr[15:8] : port_two_latch;
				next_pins.p2_oe = xq.wide ? BYTE_ONES : weak_oe(port_two_latch);
				next_pins.p0_oe = BYTE_ONES;
				next_pins.p0_o  = xq.addr[7:0];
				if (phase > ALE_END0)
				begin
					next_pins.p0_o  = xq.wdata;
					next_pins.p0_oe = xq.write ? BYTE_ONES : BYTE_ZERO;
				end
			end
			default:
			begin
			end
		endcase
		if (program_pulse_input_mode)
		begin
			next_pins.ale_oe = 1'b0;
			next_pins.ale_o  = 1'b0;
			next_pins.p1_oe  = BYTE_ZERO;
			next_pins.p2_oe  = BYTE_ZERO;
			next_pins.p0_o   = verify_byte;
			next_pins.p0_oe  = program_pulse_input_verify ? ~verify_byte : BYTE_ZERO;
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			pins <= '0;
			pins.p0_o <= BYTE_ONES;
			pins.p1_o <= BYTE_ONES;
			pins.p2_o <= BYTE_ONES;
			pins.p3_o <= BYTE_ONES;
			pins.program_store_read_strobe_n <= 1'b1;
			pins.ale_oe <= 1'b1;
		end
		else
			pins <= next_pins;
	end

	// code byte taken at the last period of each read strobe
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			code_byte  <= BYTE_ZERO;
			code_valid <= 1'b0;
		end
		else
		begin
			code_valid <= (mc == MC_FETCH) && (phase == RDS_END0 || phase == RDS_END1);
			if ((mc == MC_FETCH) && (phase == RDS_END0 || phase == RDS_END1))
				code_byte <= pins_in.p0;
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			xd_rdata <= BYTE_ZERO;
			xd_done  <= 1'b0;
		end
		else
		begin
			xd_done <= (mc == MC_DATA) && (phase == XS_END);
			if ((mc == MC_DATA) && (phase == XS_END) && !xq.write)
				xd_rdata <= pins_in.p0;
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			port_pins <= '0;
			alt_in    <= '0;
			program_pulse_input_byte <= BYTE_ZERO;
			program_pulse_input_addr <= '0;
			program_pulse_input <= 1'b0;
		end
		else
		begin
			port_pins <= {pins_in.p3, pins_in.p2, pins_in.p1, pins_in.p0};
			alt_in    <= {pins_in.p3[P3_TMR1], pins_in.p3[P3_TMR0], pins_in.p3[P3_EXTI1],
				pins_in.p3[P3_EXTI0], pins_in.p3[P3_RXD]};
			program_pulse_input_byte <= pins_in.p0;
			program_pulse_input_addr <= {pins_in.p2, pins_in.p1};
			program_pulse_input <= program_pulse_input_mode && pins_in.ale;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);

	a_p0_float_one: assert property ((mc == MC_IDLE) && !program_pulse_input_mode && !in_reset |=>
		(pins.p0_oe == ~$past(p0_latch))) else $error("port zero drives a one");
	a_p0_addr_lo: assert property ((mc == MC_DATA) && (phase == ALE_SLOT0) |=>
		(pins.p0_oe == BYTE_ONES) && (pins.p0_o == xq.addr[7:0]))
		else $error("port zero missing low address");
	a_p2_wide_hi: assert property ((mc == MC_DATA) && xq.wide && (phase == ALE_SLOT0) |=>
		(pins.p2_o == xq.addr[15:8]) && (pins.p2_oe == BYTE_ONES))
		else $error("port two missing high address");
	a_p2_byte_latch: assert property ((mc == MC_DATA) && !xq.wide && (phase == ALE_SLOT0) |=>
		(pins.p2_o == $past(port_two_latch))) else $error("port two not showing latch");
	// a reset pin hold may cut the machine cycle short
	a_ale_rate: assert property (disable iff (srst || in_reset)
		(mc == MC_FETCH) && (phase == ALE_SLOT1) |=>
		pins.ale_o [*2] ##1 !pins.ale_o [*4] ##1 pins.ale_o)
		else $error("latch strobe off rate");
	a_ale_skip: assert property ((mc == MC_DATA) && (phase == ALE_SLOT1) |=>
		!pins.ale_o [*2]) else $error("latch strobe not skipped");
	a_rds_internal: assert property ((mc == MC_IDLE) |=>
		pins.program_store_read_strobe_n) else $error("read strobe active when internal");
	a_rds_twice: assert property (disable iff (srst || in_reset)
		(mc == MC_FETCH) && (phase == RDS_BEG0) |=>
		!pins.program_store_read_strobe_n [*3] ##4 !pins.program_store_read_strobe_n)
		else $error("read strobe pattern wrong");
	a_rds_skip: assert property ((mc == MC_DATA) |=>
		pins.program_store_read_strobe_n) else $error("read strobe not skipped");
	a_strap_latch: assert property (in_reset |=>
		(strap_latch_n == $past(pins_in.external_fetch_select_n)))
		else $error("fetch select not latched");
	a_program_pulse_input_ale_in: assert property (program_pulse_input_mode |=> !pins.ale_oe)
		else $error("latch strobe driven in programming");

endmodule

// ===== design/mebp_pkg.sv
package mebp_pkg;
	// machine cycle: 6 states of 2 oscillator periods
	localparam int unsigned MC_CLKS   = 12;
	localparam logic [3:0]  PH_LAST   = 4'hb;
	localparam logic [3:0]  ALE_SLOT0 = 4'h0;
	localparam logic [3:0]  ALE_SLOT1 = 4'h6;
	localparam logic [3:0]  ALE_END0  = 4'h1;
	localparam logic [3:0]  ALE_END1  = 4'h7;
	localparam logic [3:0]  RDS_BEG0  = 4'h3;
	localparam logic [3:0]  RDS_END0  = 4'h5;
	localparam logic [3:0]  RDS_BEG1  = 4'h9;
	localparam logic [3:0]  RDS_END1  = 4'hb;
	localparam logic [3:0]  XS_BEG    = 4'h3;
	localparam logic [3:0]  XS_END    = 4'ha;
	localparam int unsigned RST_MACH  = 2;
	localparam int unsigned RST_CLKS  = RST_MACH * MC_CLKS;
	localparam logic [4:0]  RST_MAX   = 5'(RST_CLKS);
	localparam logic [7:0]  BYTE_ONES = 8'hff;
	localparam logic [7:0]  BYTE_ZERO = 8'h00;
	localparam logic [1:0]  LOCK_NONE = 2'h0;
	// port-three pin positions
	localparam int unsigned P3_RXD  = 0;
	localparam int unsigned P3_TXD  = 1;
	localparam int unsigned P3_EXTI0 = 2;
	localparam int unsigned P3_EXTI1 = 3;
	localparam int unsigned P3_TMR0  = 4;
	localparam int unsigned P3_TMR1  = 5;
	localparam int unsigned P3_WR   = 6;
	localparam int unsigned P3_RD   = 7;

	typedef enum logic [2:0]
	{
		MC_IDLE  = 3'b001,
		MC_FETCH = 3'b010,
		MC_DATA  = 3'b100
	} mebp_mc_t;

	typedef struct packed
	{
		logic [7:0] p0;
		logic [7:0] p1;
		logic [7:0] p2;
		logic [7:0] p3;
		logic       ale;
		logic       reset_pin;
		logic       external_fetch_select_n;
	} mebp_pin_in_t;

	typedef struct packed
	{
		logic [7:0] p0_o;
		logic [7:0] p0_oe;
		logic [7:0] p1_o;
		logic [7:0] p1_oe;
		logic [7:0] p2_o;
		logic [7:0] p2_oe;
		logic [7:0] p3_o;
		logic [7:0] p3_oe;
		logic       ale_o;
		logic       ale_oe;
		logic       program_store_read_strobe_n;
	} mebp_pin_out_t;

	typedef struct packed
	{
		logic        write;
		logic        wide;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} mebp_xreq_t;
endpackage

// ===== test/mebp_mem_model.sv
`timescale 1ns/1ns
module mebp_mem_model
	import mebp_pkg::*;
(
	// pins
	input  wire logic          clk,
	input  wire mebp_pin_out_t pins,
	input  wire logic [7:0]    p0,
	// port zero drive
	output logic [7:0]         drv,
	output logic               drv_en
);
	logic [7:0] lat;
	logic [7:0] mem [256];

	always_ff @(posedge clk)
	begin
		if (pins.ale_o)
			lat <= p0;
		if (!pins.p3_o[P3_WR])
			mem[lat] <= p0;
	end

	// code bytes derived from the latched address
	always_comb
	begin
		drv_en = !pins.program_store_read_strobe_n || !pins.p3_o[P3_RD];
		drv = pins.p3_o[P3_RD] ? lat ^ 8'h5a : mem[lat];
	end
endmodule

// ===== test/tb_top.sv
`timescale 1ns/1ns
module tb_top
	import mebp_pkg::*;
;
	logic          clk = 1'b0;
	logic          srst = 1'b1;
	mebp_pin_in_t  pi;
	mebp_pin_out_t po;
	mebp_xreq_t    xq;
	logic [1:0]    lock_bits, port_sel;
	logic          program_pulse_input_mode, program_pulse_input_verify, port_wr, xd_valid, serial_tx, rst_pin, sel_n;
	logic          ale_ext, drv_en, code_valid, fetch_ext, xd_ready, xd_done;
	logic          ale_p = 1'b1;
	logic          rs_p = 1'b1;
	logic          pulse, in_reset;
	logic [7:0]    verify_byte, port_wdata, ext1, ext2, ext3, p0_ext, drv, lv;
	logic [7:0]    code_byte, xd_rdata, program_pulse_input_byte;
	logic [7:0]    pl [4];
	logic [15:0]   fetch_addr, program_pulse_input_addr, a;
	logic [31:0]   port_pins;
	logic [4:0]    alt_in;
	logic [8:0]    exp_q [$];
	logic [8:0]    e;
	int            seed = 32'hf35a;
	int            bad_count, checks_done, s_a, s_r;
	int            cycles = 0;
	int            n_ale = 0;
	int            n_rs = 0;

	always #25 clk = ~clk;

	mebp_bus_pins dut (.clk(clk), .srst(srst), .pins_in(pi), .pins(po),
		.lock_bits(lock_bits), .program_pulse_input_mode(program_pulse_input_mode), .program_pulse_input_verify(program_pulse_input_verify),
		.verify_byte(verify_byte), .port_wr(port_wr), .port_sel(port_sel),
		.port_wdata(port_wdata), .port_pins(port_pins), .fetch_addr(fetch_addr),
		.code_byte(code_byte), .code_valid(code_valid), .fetch_external(fetch_ext),
		.xd_valid(xd_valid), .xd_req(xq), .xd_ready(xd_ready), .xd_rdata(xd_rdata),
		.xd_done(xd_done), .serial_tx(serial_tx), .alt_in(alt_in),
		.program_pulse_input_byte(program_pulse_input_byte), .program_pulse_input_addr(program_pulse_input_addr), .program_pulse_input(pulse),
		.in_reset(in_reset));

	mebp_mem_model mem (.clk(clk), .pins(po), .p0(pi.p0), .drv(drv), .drv_en(drv_en));

	// wire levels: pull-ups on ports one to three, float pattern on port zero
	always_comb
	begin
		pi.p0 = (po.p0_oe & po.p0_o) | (~po.p0_oe & (drv_en ? drv : p0_ext));
		pi.p1 = (po.p1_o | ~po.p1_oe) & ext1;
		pi.p2 = (po.p2_o | ~po.p2_oe) & ext2;
		pi.p3 = (po.p3_o | ~po.p3_oe) & ext3;
		pi.ale = po.ale_oe ? po.ale_o : ale_ext;
		pi.reset_pin = rst_pin;
		pi.external_fetch_select_n = sel_n;
	end

	always @(negedge clk)
		if (!program_pulse_input_mode)
			p0_ext <= ~p0_ext;

	always @(posedge clk)
	begin
		ale_p <= po.ale_o;
		rs_p <= po.program_store_read_strobe_n;
		n_ale <= n_ale + int'(po.ale_o && !ale_p);
		n_rs <= n_rs + int'(!po.program_store_read_strobe_n && rs_p);
		cycles <= cycles + 1;
		if (cycles == 4000)
		begin
			bad_count++;
			end_sim();
		end
	end

	always @(negedge clk)
	begin
		if (xd_done === 1'b1)
		begin
			e = exp_q.pop_front();
			if (e[8])
				chk(xd_rdata === e[7:0], "read data");
		end
		if (code_valid === 1'b1)
			chk(code_byte === (fetch_addr[7:0] ^ 8'h5a), "code byte");
	end

	task automatic chk(input logic ok, input string m);
		checks_done++;
		if (ok !== 1'b1)
		begin
			bad_count++;
			$display("FAIL %0t %s", $time, m);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic wport(input logic [1:0] s, input logic [7:0] d);
		{port_wr, port_sel, port_wdata} = {1'b1, s, d};
		cyc(1);
		port_wr = 1'b0;
		cyc(1);
	endtask

	task automatic xd(input logic w, input logic wd, input logic [15:0] ad, input logic [7:0] d);
		xq = '{w, wd, ad, d};
		xd_valid = 1'b1;
		exp_q.push_back({~w, d});
		for (int i = 0; i < 30 && xd_ready !== 1'b1; i++)
			cyc(1);
		cyc(1);
		xd_valid = 1'b0;
		cyc(1);
	endtask

	task automatic end_sim();
		if (bad_count == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	initial
	begin
		{lock_bits, program_pulse_input_mode, program_pulse_input_verify, port_wr, xd_valid, rst_pin, ale_ext} = '0;
		{serial_tx, sel_n, port_sel, port_wdata, verify_byte, xq} = '1;
		{ext1, ext2, ext3, p0_ext} = '1;
		{bad_count, checks_done} = '0;
		fetch_addr = 16'($random(seed));
		cyc(6);
		srst = 1'b0;
		cyc(2);
		rst_pin = 1'b1;
		cyc(12);
		chk(in_reset === 1'b0, "short reset");
		cyc(20);
		chk(in_reset === 1'b1, "reset missed");
		rst_pin = 1'b0;
		cyc(2);
		{s_a, s_r} = {n_ale, n_rs};
		cyc(120);
		chk(n_ale - s_a == 20 && fetch_ext === 1'b0, "latch rate");
		chk(n_rs == s_r, "read strobe");
		{ext1, ext3} = 16'($random(seed));
		for (int k = 0; k < 4; k++)
		begin
			pl[k] = 8'($random(seed)) | (k == 3 ? 8'hc0 : 8'h00);
			wport(2'(k), pl[k]);
		end
		cyc(2);
		chk(po.p0_oe === ~pl[0], "open drain");
		chk({po.p3_oe, po.p2_oe, po.p1_oe} === ~{pl[3], pl[2], pl[1]}, "pull-up");
		chk(port_pins[31:8] === {pl[3] & ext3, pl[2], pl[1] & ext1}, "pin read");
		chk(alt_in === {pi.p3[5:2], pi.p3[0]}, "alt inputs");
		serial_tx = 1'b0;
		cyc(2);
		chk(pi.p3[P3_TXD] === 1'b0, "serial out");
		{serial_tx, ext1, ext3} = '1;
		wport(2'h0, 8'hff);
		wport(2'h1, 8'hff);
		wport(2'h3, 8'hff);
		sel_n = 1'b0;
		cyc(2);
		chk(fetch_ext === 1'b1, "strap");
		cyc(12);
		s_r = n_rs;
		cyc(120);
		chk(n_rs - s_r == 20, "fetch strobes");
		chk(po.p2_o === fetch_addr[15:8] && po.p2_oe === 8'hff, "high address");
		a = 16'($random(seed));
		lv = 8'($random(seed));
		xd(1'b1, 1'b1, a, lv);
		cyc(1);
		chk(po.ale_o === 1'b1 && po.p0_o === a[7:0] && po.p2_o === a[15:8], "address");
		cyc(3);
		chk(po.p0_o === lv && po.p0_oe === 8'hff && !po.p3_o[P3_WR], "write");
		xd(1'b0, 1'b0, a, lv);
		{s_a, s_r} = {n_ale, n_rs};
		cyc(1);
		chk(po.p2_o === pl[2], "port two latch");
		cyc(22);
		chk(n_ale - s_a == 3, "skipped latch");
		chk(n_rs - s_r == 2, "skipped strobes");
		for (int k = 0; k < 6; k++)
		begin
			a = 16'($random(seed));
			lv = 8'($random(seed));
			xd(1'b1, k[0], a, lv);
			xd(1'b0, k[1], a, lv);
		end
		cyc(24);
		lock_bits = 2'h1;
		rst_pin = 1'b1;
		cyc(30);
		rst_pin = 1'b0;
		cyc(2);
		sel_n = 1'b1;
		cyc(2);
		chk(fetch_ext === 1'b1, "latched strap");
		lock_bits = 2'h0;
		cyc(2);
		chk(fetch_ext === 1'b0, "live strap");
		program_pulse_input_mode = 1'b1;
		{ext1, ext2, p0_ext} = 24'($random(seed));
		cyc(3);
		chk(program_pulse_input_addr === {pi.p2, pi.p1} && program_pulse_input_byte === pi.p0, "program in");
		ale_ext = 1'b1;
		cyc(2);
		chk(po.ale_oe === 1'b0 && pulse === 1'b1, "program pulse");
		verify_byte = 8'($random(seed));
		{program_pulse_input_verify, p0_ext} = {1'b1, 8'hff};
		cyc(3);
		chk(pi.p0 === verify_byte, "verify out");
		chk(exp_q.size() == 0, "missing done");
		end_sim();
	end
endmodule
